//--- pkg/fiac_params.svh
// Constants for the flash service and user configuration block
`ifndef FIAC_PARAMS_SVH
`define FIAC_PARAMS_SVH
// Function codes carried in the accumulator
`define FIAC_FN_MISC_READ 8'h03
`define FIAC_FN_ERASE 8'h04
`define FIAC_FN_SECTOR_CRC 8'h05
`define FIAC_FN_GLOBAL_CRC 8'h06
`define FIAC_FN_USER_READ 8'h07
// Register selectors of the miscellaneous read
`define FIAC_SEL_CONFIG 8'h00
`define FIAC_SEL_BOOT_VECTOR 8'h02
`define FIAC_SEL_STATUS 8'h03
`define FIAC_SEL_SECURITY_FIRST 8'h08
`define FIAC_SEL_SECURITY_LAST 8'h0F
// Erase selectors
`define FIAC_ERASE_PAGE 8'h00
`define FIAC_ERASE_SECTOR 8'h01
// Error status values, one flag each; upper nibble always zero
`define FIAC_ST_OK 8'h00
`define FIAC_ST_OP_INTERRUPTED 8'h01
`define FIAC_ST_SECURITY_VIOLATION 8'h02
`define FIAC_ST_HIGH_VOLTAGE_ERROR 8'h04
`define FIAC_ST_VERIFY_ERROR 8'h08
`define FIAC_ST_BAD_CALL 8'h02
// Fields of user_config_byte
`define FIAC_CFG_OSC_MSB 2
`define FIAC_CFG_OSC_LSB 0
`define FIAC_CFG_WATCHDOG_SAFETY_ENABLE_BIT 4
`define FIAC_CFG_BOE_BIT 5
`define FIAC_CFG_RPE_BIT 6
`define FIAC_CFG_WATCHDOG_RESET_ENABLE_BIT 7
// Oscillator type codes
`define FIAC_OSC_EXT_CLOCK 3'h7
`define FIAC_OSC_WATCHDOG 3'h4
`define FIAC_OSC_INTERNAL_RC 3'h3
`define FIAC_OSC_LOW_XTAL 3'h2
`define FIAC_OSC_MED_XTAL 3'h1
`define FIAC_OSC_HIGH_XTAL 3'h0
// Unprogrammed values of the configuration region
`define FIAC_UCFG_UNPROG 8'h63
`define FIAC_BOOTVEC_UNPROG 8'h1F
`define FIAC_BOOTSTAT_UNPROG 8'h01
`define FIAC_SECURITY_UNPROG 8'h00
// Flash geometry
`define FIAC_ADDR_W 14
`define FIAC_MEM_WORDS 8208
`define FIAC_CODE_BYTES 8192
`define FIAC_CFG_BASE 14'h2000
`define FIAC_CFG_WORDS 16
`define FIAC_FLASH_BYTES 14'h2000
`define FIAC_PAGE_BYTES 14'h0040
`define FIAC_SECTOR_BYTES 14'h0400
`define FIAC_SECTOR_COUNT 8'h08
`define FIAC_ERASED_BYTE 8'h00
// CRC
`define FIAC_CRC_POLY 32'h04C11DB7
`define FIAC_CRC_INIT 32'hFFFFFFFF
`endif

//--- pkg/fiac_pkg.sv
// Types shared by the flash service block
package fiac_pkg;
    typedef enum logic [2:0] {
        FIAC_LOAD = 3'h0,
        FIAC_LOAD_WAIT = 3'h1,
        FIAC_IDLE = 3'h2,
        FIAC_READ = 3'h3,
        FIAC_READ_WAIT = 3'h4,
        FIAC_ERASE = 3'h5,
        FIAC_CRC = 3'h6
    } fiac_state_t;

    typedef struct packed {
        fiac_state_t state;
        logic [7:0] ucfg;
        logic [13:0] cnt;
        logic [13:0] left;
        logic pend;
        logic [31:0] crc;
        logic [7:0] r4;
        logic [7:0] r5;
        logic [7:0] r6;
        logic [7:0] r7;
        logic carry;
        logic done;
        logic pin_s1;
        logic pin_s2;
        logic por_s1;
        logic por_s2;
        logic wdt_reset;
        logic wdt_irq;
    } fiac_core_state_t;
endpackage

//--- verilog/fiac_mem.sv
// Byte-wide flash array with the configuration region above user code
`include "fiac_params.svh"
module fiac_mem (
    // Clock
    input wire logic i_ref_clk,
    input wire logic i_ce,
    // Access port
    input wire logic [13:0] i_addr,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:`FIAC_MEM_WORDS-1];

    // Non-volatile contents start unprogrammed; not cleared by reset
    initial begin
        for (int i = 0; i < `FIAC_CODE_BYTES; i++) begin
            mem[i] = `FIAC_ERASED_BYTE;
        end
        for (int i = 0; i < `FIAC_CFG_WORDS; i++) begin
            mem[`FIAC_CODE_BYTES + i] = `FIAC_SECURITY_UNPROG;
        end
        mem[`FIAC_CODE_BYTES + 0] = `FIAC_UCFG_UNPROG;
        mem[`FIAC_CODE_BYTES + 2] = `FIAC_BOOTVEC_UNPROG;
        mem[`FIAC_CODE_BYTES + 3] = `FIAC_BOOTSTAT_UNPROG;
    end

    // Registered read, write-first not needed: erase never reads back
    // Plain always, since the preset image above also fills the same array
    always @(posedge i_ref_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_addr] <= i_wdata;
            end
            o_rdata <= mem[i_addr];
        end
    end
endmodule

//--- verilog/fiac_core.sv
// Flash service calls and power-up user configuration
`include "fiac_params.svh"
module fiac_core (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Service call from the processor
    input wire logic i_call_valid,
    input wire logic [7:0] i_func,
    input wire logic [7:0] i_r4,
    input wire logic [7:0] i_r5,
    input wire logic [7:0] i_r7,
    input wire logic i_key_ok,
    input wire logic i_irq,
    input wire logic i_hv_fault,
    // Service results
    output logic o_busy,
    output logic o_done,
    output logic o_carry,
    output logic [7:0] o_r4,
    output logic [7:0] o_r5,
    output logic [7:0] o_r6,
    output logic [7:0] o_r7,
    // Latched configuration
    output logic [2:0] o_osc_type_select,
    output logic o_osc_code_valid,
    output logic o_watchdog_safety_enable,
    output logic o_brownout_detect_enable,
    output logic o_config_ready,
    // Shared reset pin, active low at the pin
    input wire logic i_shared_reset_pin_n,
    input wire logic i_power_up,
    output logic o_pin_is_reset,
    output logic o_pin_reset_req,
    output logic o_pin_input,
    // Watchdog
    input wire logic i_wdt_timeout,
    output logic o_wdt_reset_req,
    output logic o_wdt_irq
);
    fiac_pkg::fiac_core_state_t s_reg;
    fiac_pkg::fiac_core_state_t s_next;
    logic [13:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_rdata;

    // One byte of MSB-first CRC-32
    function automatic logic [31:0] fiac_crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[31] ^ d[i]) begin
                r = {r[30:0], 1'b0} ^ `FIAC_CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Selectors that name a real register
    function automatic logic fiac_sel_ok(input logic [7:0] sel);
        return (sel == `FIAC_SEL_CONFIG) || (sel == `FIAC_SEL_BOOT_VECTOR) ||
            (sel == `FIAC_SEL_STATUS) ||
            ((sel >= `FIAC_SEL_SECURITY_FIRST) && (sel <= `FIAC_SEL_SECURITY_LAST));
    endfunction

    // The six defined oscillator codes; others are reserved
    function automatic logic fiac_osc_ok(input logic [2:0] osc);
        return (osc == `FIAC_OSC_EXT_CLOCK) || (osc == `FIAC_OSC_WATCHDOG) ||
            (osc == `FIAC_OSC_INTERNAL_RC) || (osc == `FIAC_OSC_LOW_XTAL) ||
            (osc == `FIAC_OSC_MED_XTAL) || (osc == `FIAC_OSC_HIGH_XTAL);
    endfunction

    fiac_mem u_mem (
        .i_ref_clk(i_ref_clk),
        .i_ce(i_ce),
        .i_addr(mem_addr),
        .i_we(mem_we),
        .i_wdata(`FIAC_ERASED_BYTE),
        .o_rdata(mem_rdata)
    );

    // Next state of the whole block
    always_comb begin
        logic [7:0] err;
        logic finish;
        err = `FIAC_ST_OK;
        finish = 1'b0;
        s_next = s_reg;
        s_next.done = 1'b0;
        mem_addr = s_reg.cnt;
        mem_we = 1'b0;
        // Pin and power-up flag come from outside the clock domain
        s_next.pin_s1 = i_shared_reset_pin_n;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.por_s1 = i_power_up;
        s_next.por_s2 = s_reg.por_s1;
        s_next.wdt_reset = i_wdt_timeout & s_reg.ucfg[`FIAC_CFG_WATCHDOG_RESET_ENABLE_BIT];
        s_next.wdt_irq = i_wdt_timeout;
        unique case (s_reg.state)
            fiac_pkg::FIAC_LOAD: begin
                mem_addr = `FIAC_CFG_BASE;
                s_next.state = fiac_pkg::FIAC_LOAD_WAIT;
            end
            fiac_pkg::FIAC_LOAD_WAIT: begin
                // Only this state writes ucfg, so later calls cannot alter it
                s_next.ucfg = mem_rdata;
                s_next.state = fiac_pkg::FIAC_IDLE;
            end
            fiac_pkg::FIAC_IDLE: begin
                if (i_call_valid) begin
                    unique case (i_func)
                        `FIAC_FN_MISC_READ: begin
                            if (fiac_sel_ok(i_r7)) begin
                                s_next.cnt = `FIAC_CFG_BASE | {6'h00, i_r7};
                                s_next.state = fiac_pkg::FIAC_READ;
                            end else begin
                                err = `FIAC_ST_BAD_CALL;
                            end
                        end
                        `FIAC_FN_ERASE: begin
                            if (!i_key_ok) begin
                                err = `FIAC_ST_SECURITY_VIOLATION;
                            end else if (i_r4[7:5] != 3'h0) begin
                                err = `FIAC_ST_BAD_CALL;
                            end else if (i_r7 == `FIAC_ERASE_PAGE) begin
                                s_next.cnt = {1'b0, i_r4[4:0], i_r5[7:6], 6'h00};
                                s_next.left = `FIAC_PAGE_BYTES;
                                s_next.state = fiac_pkg::FIAC_ERASE;
                            end else if (i_r7 == `FIAC_ERASE_SECTOR) begin
                                s_next.cnt = {1'b0, i_r4[4:2], 10'h000};
                                s_next.left = `FIAC_SECTOR_BYTES;
                                s_next.state = fiac_pkg::FIAC_ERASE;
                            end else begin
                                err = `FIAC_ST_BAD_CALL;
                            end
                        end
                        `FIAC_FN_SECTOR_CRC: begin
                            if (i_r7 < `FIAC_SECTOR_COUNT) begin
                                s_next.cnt = {1'b0, i_r7[2:0], 10'h000};
                                s_next.left = `FIAC_SECTOR_BYTES;
                                s_next.crc = `FIAC_CRC_INIT;
                                s_next.pend = 1'b0;
                                s_next.state = fiac_pkg::FIAC_CRC;
                            end else begin
                                err = `FIAC_ST_BAD_CALL;
                            end
                        end
                        `FIAC_FN_GLOBAL_CRC: begin
                            s_next.cnt = 14'h0000;
                            s_next.left = `FIAC_FLASH_BYTES;
                            s_next.crc = `FIAC_CRC_INIT;
                            s_next.pend = 1'b0;
                            s_next.state = fiac_pkg::FIAC_CRC;
                        end
                        `FIAC_FN_USER_READ: begin
                            if (i_r4[7:5] == 3'h0) begin
                                s_next.cnt = {1'b0, i_r4[4:0], i_r5};
                                s_next.state = fiac_pkg::FIAC_READ;
                            end else begin
                                err = `FIAC_ST_BAD_CALL;
                            end
                        end
                        default: begin
                            err = `FIAC_ST_BAD_CALL;
                        end
                    endcase
                end
            end
            fiac_pkg::FIAC_READ: begin
                s_next.state = fiac_pkg::FIAC_READ_WAIT;
            end
            fiac_pkg::FIAC_READ_WAIT: begin
                s_next.r7 = mem_rdata;
                finish = 1'b1;
            end
            fiac_pkg::FIAC_ERASE: begin
                // Abort before the write so the handler can fetch from flash
                if (i_irq) begin
                    err = `FIAC_ST_OP_INTERRUPTED;
                end else if (i_hv_fault) begin
                    err = `FIAC_ST_HIGH_VOLTAGE_ERROR;
                end else begin
                    mem_we = 1'b1;
                    s_next.cnt = s_reg.cnt + 14'h0001;
                    s_next.left = s_reg.left - 14'h0001;
                    if (s_reg.left == 14'h0001) begin
                        s_next.r7 = `FIAC_ST_OK;
                        finish = 1'b1;
                    end
                end
            end
            fiac_pkg::FIAC_CRC: begin
                if (i_irq) begin
                    err = `FIAC_ST_OP_INTERRUPTED;
                end else begin
                    // Read data lags the address by one cycle
                    if (s_reg.pend) begin
                        s_next.crc = fiac_crc_byte(s_reg.crc, mem_rdata);
                    end
                    s_next.pend = (s_reg.left != 14'h0000);
                    if (s_reg.left != 14'h0000) begin
                        s_next.cnt = s_reg.cnt + 14'h0001;
                        s_next.left = s_reg.left - 14'h0001;
                    end else if (!s_reg.pend) begin
                        s_next.r4 = s_reg.crc[31:24];
                        s_next.r5 = s_reg.crc[23:16];
                        s_next.r6 = s_reg.crc[15:8];
                        s_next.r7 = s_reg.crc[7:0];
                        finish = 1'b1;
                    end
                end
            end
            default: begin
                s_next.state = fiac_pkg::FIAC_IDLE;
            end
        endcase
        // Common ending of every call
        if (finish) begin
            s_next.carry = 1'b0;
            s_next.done = 1'b1;
            s_next.state = fiac_pkg::FIAC_IDLE;
        end
        if (err != `FIAC_ST_OK) begin
            s_next.r4 = s_reg.crc[31:24];
            s_next.r5 = s_reg.crc[23:16];
            s_next.r6 = s_reg.crc[15:8];
            s_next.r7 = err;
            s_next.carry = 1'b1;
            s_next.done = 1'b1;
            s_next.pend = 1'b0;
            s_next.state = fiac_pkg::FIAC_IDLE;
        end
    end

    // State register; low enable freezes everything
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '0;
            s_reg.state <= fiac_pkg::FIAC_LOAD;
            s_reg.ucfg <= `FIAC_UCFG_UNPROG;
            s_reg.pin_s1 <= 1'b1;
            s_reg.pin_s2 <= 1'b1;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    // Results and configuration views
    assign o_busy = (s_reg.state != fiac_pkg::FIAC_IDLE);
    assign o_done = s_reg.done;
    assign o_carry = s_reg.carry;
    assign o_r4 = s_reg.r4;
    assign o_r5 = s_reg.r5;
    assign o_r6 = s_reg.r6;
    assign o_r7 = s_reg.r7;
    assign o_config_ready = (s_reg.state != fiac_pkg::FIAC_LOAD) &&
        (s_reg.state != fiac_pkg::FIAC_LOAD_WAIT);
    assign o_osc_type_select = s_reg.ucfg[`FIAC_CFG_OSC_MSB:`FIAC_CFG_OSC_LSB];
    assign o_osc_code_valid = fiac_osc_ok(o_osc_type_select);
    assign o_watchdog_safety_enable = s_reg.ucfg[`FIAC_CFG_WATCHDOG_SAFETY_ENABLE_BIT];
    assign o_brownout_detect_enable = s_reg.ucfg[`FIAC_CFG_BOE_BIT];
    // Pin is reset while powering up, before the byte is known, or while the RPE bit of ucfg is set
    assign o_pin_is_reset = s_reg.por_s2 || !o_config_ready ||
        s_reg.ucfg[`FIAC_CFG_RPE_BIT];
    assign o_pin_reset_req = o_pin_is_reset && !s_reg.pin_s2;
    assign o_pin_input = s_reg.pin_s2;
    assign o_wdt_reset_req = s_reg.wdt_reset;
    assign o_wdt_irq = s_reg.wdt_irq;
endmodule

//--- testbench/fiac_core_monitor.sv
// Concurrent checks on the ports of the flash service block
`include "fiac_params.svh"
module fiac_core_monitor (
    // Clock, reset and call port
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_call_valid,
    input wire logic [7:0] i_func,
    input wire logic [7:0] i_r7,
    input wire logic i_key_ok,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_carry,
    input wire logic [7:0] o_r7,
    // Configuration
    input wire logic [2:0] o_osc_type_select,
    input wire logic o_osc_code_valid,
    input wire logic o_watchdog_safety_enable,
    input wire logic o_brownout_detect_enable,
    input wire logic o_config_ready,
    // Pin and watchdog
    input wire logic i_shared_reset_pin_n,
    input wire logic i_power_up,
    input wire logic o_pin_is_reset,
    input wire logic o_pin_reset_req,
    input wire logic o_pin_input,
    input wire logic i_wdt_timeout,
    input wire logic o_wdt_reset_req,
    input wire logic o_wdt_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // A call counts only when the block is idle and enabled
    logic take;
    assign take = i_ce && i_call_valid && !o_busy;
    // Call results
    a_bad_code: assert property (take && (i_func < 8'h03 || i_func > 8'h07) |=>
        o_done && o_carry && o_r7 == `FIAC_ST_BAD_CALL) else $error("Bad code not refused");
    a_bad_sel: assert property (take && i_func == 8'h03 && i_r7 inside {1, [4:7], [16:255]}
        |=> o_done && o_carry && o_r7 == `FIAC_ST_BAD_CALL) else $error("Bad selector taken");
    a_erase_key: assert property (take && i_func == 8'h04 && !i_key_ok |=>
        o_done && o_carry && o_r7 == `FIAC_ST_BAD_CALL) else $error("Keyless erase taken");
    a_read_cfg: assert property (take && i_func == 8'h03 && i_r7 == 8'h00 |-> ##3
        o_done && !o_carry && o_r7[2:0] == o_osc_type_select && o_r7[4] == o_watchdog_safety_enable
        && o_r7[5] == o_brownout_detect_enable) else $error("Config read wrong");
    a_status_bits: assert property (o_done && o_carry |-> o_r7[7:4] == 4'h0 && o_r7 != 8'h00)
        else $error("Error status malformed");
    // Configuration stays put once loaded
    a_cfg_frozen: assert property (o_config_ready && $past(o_config_ready) |->
        $stable(o_osc_type_select) && $stable(o_brownout_detect_enable)) else $error("Config moved");
    a_osc_valid: assert property (o_osc_code_valid == !(o_osc_type_select inside {3'h5, 3'h6}))
        else $error("Oscillator code flag wrong");
    // Watchdog and pin
    a_wdt_irq: assert property (i_wdt_timeout && i_ce |=> o_wdt_irq)
        else $error("Watchdog interrupt missing");
    a_wdt_gate: assert property (o_wdt_reset_req |-> o_wdt_irq)
        else $error("Watchdog reset without timeout");
    // Pin view trails the pin by the two synchroniser stages
    a_pin_req: assert property (o_pin_input == $past(i_shared_reset_pin_n, 2) &&
        o_pin_reset_req == (o_pin_is_reset && !o_pin_input)) else $error("Pin reset request wrong");
    a_pin_powerup: assert property (i_power_up [*3] |-> o_pin_is_reset)
        else $error("Power-up did not force pin reset");
    c_erase: cover property (take && i_func == 8'h04 && i_key_ok);
    c_error: cover property (o_done && o_carry);
    c_wdt: cover property (o_wdt_irq);
endmodule
bind fiac_core fiac_core_monitor u_mon (.*);

//--- testbench/fiac_cpu_model.sv
// Processor-side model issuing service calls and collecting results
module fiac_cpu_model (
    // Status from the block
    input wire logic i_ref_clk,
    input wire logic i_busy,
    input wire logic i_done,
    input wire logic i_carry,
    input wire logic [31:0] i_res,
    // Call request
    output logic o_call_valid,
    output logic [7:0] o_func,
    output logic [7:0] o_r4,
    output logic [7:0] o_r5,
    output logic [7:0] o_r7,
    output logic o_key_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] res;
    logic res_c;
    int res_cyc;
    initial begin
        o_call_valid = 1'b0;
        {o_func, o_r4, o_r5, o_r7, o_key_ok} = '0;
    end
    // One call; fields are scrambled once withdrawn so stale values never help
    task automatic call(input logic [7:0] f, hi, lo, sel, input logic k);
        int n;
        n = 0;
        while (i_busy) @(negedge i_ref_clk);
        o_call_valid = 1'b1;
        {o_func, o_r4, o_r5, o_r7, o_key_ok} = {f, hi, lo, sel, k};
        @(negedge i_ref_clk);
        o_call_valid = 1'b0;
        {o_func, o_r4, o_r5, o_r7, o_key_ok} = ~{f, hi, lo, sel, k};
        while (!i_done && n < 9000) begin
            @(negedge i_ref_clk);
            n++;
        end
        res = i_res;
        res_c = i_carry;
        res_cyc = n + 1;
    endtask
endmodule

//--- testbench/flash_iap_config_tb_top.sv
// Self-checking bench for the flash service block
`include "fiac_params.svh"
module flash_iap_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_irq = 1'b0;
    logic i_hv_fault = 1'b0;
    logic i_pin_n = 1'b1;
    logic i_power_up = 1'b0;
    logic i_wdt_timeout = 1'b0;
    logic ce = 1'b1;
    logic valid, key, busy, done, carry, osc_ok, watchdog_safety_enable, brownout_detect_enable, ready;
    logic is_rst, pin_req, pin_in, wdt_rst, wdt_irq;
    logic [7:0] func, a4, a5, a7, r4, r5, r6, r7;
    logic [2:0] osc;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Clock and hang guard
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            conclude();
        end
    end
    fiac_core dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(ce), .i_call_valid(valid),
        .i_func(func), .i_r4(a4), .i_r5(a5), .i_r7(a7), .i_key_ok(key), .i_irq(i_irq),
        .i_hv_fault(i_hv_fault), .o_busy(busy), .o_done(done), .o_carry(carry), .o_r4(r4),
        .o_r5(r5), .o_r6(r6), .o_r7(r7), .o_osc_type_select(osc), .o_osc_code_valid(osc_ok),
        .o_watchdog_safety_enable(watchdog_safety_enable), .o_brownout_detect_enable(brownout_detect_enable), .o_config_ready(ready),
        .i_shared_reset_pin_n(i_pin_n), .i_power_up(i_power_up), .o_pin_is_reset(is_rst),
        .o_pin_reset_req(pin_req), .o_pin_input(pin_in), .i_wdt_timeout(i_wdt_timeout),
        .o_wdt_reset_req(wdt_rst), .o_wdt_irq(wdt_irq));
    fiac_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_busy(busy), .i_done(done), .i_carry(carry),
        .i_res({r4, r5, r6, r7}), .o_call_valid(valid), .o_func(func), .o_r4(a4), .o_r5(a5),
        .o_r7(a7), .o_key_ok(key));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Expected CRC of erased flash, computed bit by bit
    function automatic logic [31:0] crc_zero(input int n);
        logic [31:0] c;
        c = `FIAC_CRC_INIT;
        for (int i = 0; i < n * 8; i++) c = c[31] ? (c << 1) ^ `FIAC_CRC_POLY : c << 1;
        return c;
    endfunction
    task automatic do_reset(input int n);
        i_rst = 1'b1;
        repeat (n) @(negedge i_ref_clk);
        check(32'({busy, ready}), 32'h2);
        i_rst = 1'b0;
        repeat (3) @(negedge i_ref_clk);
    endtask
    task automatic t_cfg();
        check(32'({osc, osc_ok, ready}), 32'({`FIAC_OSC_INTERNAL_RC, 2'b11}));
        check(32'({watchdog_safety_enable, brownout_detect_enable}), 32'h1);
    endtask
    task automatic t_misc();
        logic [7:0] e;
        for (int s = 0; s < 17; s++) begin
            e = s == 0 ? `FIAC_UCFG_UNPROG : s == 2 ? `FIAC_BOOTVEC_UNPROG : s == 3 ?
                `FIAC_BOOTSTAT_UNPROG : (s > 7 && s < 16) ? `FIAC_SECURITY_UNPROG : `FIAC_ST_BAD_CALL;
            cpu.call(`FIAC_FN_MISC_READ, 8'h00, 8'h00, 8'(s), 1'b0);
            check(32'({cpu.res_c, cpu.res[7:0]}), 32'({e == `FIAC_ST_BAD_CALL, e}));
        end
    endtask
    task automatic t_bad();
        logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'hFF};
        foreach (codes[i]) begin
            cpu.call(codes[i], 8'h00, 8'h00, 8'h00, 1'b1);
            check(32'({cpu.res_c, cpu.res[7:0]}), 32'h102);
        end
        cpu.call(`FIAC_FN_USER_READ, 8'h20, 8'h00, 8'h00, 1'b0);
        check(32'(cpu.res_c), 32'h1);
        // A legal address right after a refused one must be served
        cpu.call(`FIAC_FN_USER_READ, 8'h1F, 8'hFF, 8'h00, 1'b0);
        check(32'({cpu.res_c, cpu.res[7:0]}), 32'h000);
    endtask
    task automatic t_erase();
        cpu.call(`FIAC_FN_ERASE, 8'h00, 8'h40, `FIAC_ERASE_PAGE, 1'b0);
        check(32'({cpu.res_c, cpu.res[7:0]}), 32'h102);
        cpu.call(`FIAC_FN_ERASE, 8'h00, 8'h40, `FIAC_ERASE_PAGE, 1'b1);
        check(32'({cpu.res_c, cpu.res[7:0]}), 32'h000);
        check(32'(cpu.res_cyc), 32'(`FIAC_PAGE_BYTES) + 32'd1);
        // Abort a sector erase midway, once by interrupt and once by pump fault
        for (int k = 0; k < 2; k++) begin
            fork
                cpu.call(`FIAC_FN_ERASE, 8'h04, 8'h00, `FIAC_ERASE_SECTOR, 1'b1);
                begin
                    repeat (20) @(negedge i_ref_clk);
                    if (k == 0) i_irq = 1'b1;
                    else i_hv_fault = 1'b1;
                end
            join
            {i_irq, i_hv_fault} = 2'b00;
            check(32'({cpu.res_c, cpu.res[7:0]}), k == 0 ? 32'h101 : 32'h104);
        end
    endtask
    task automatic t_crc();
        cpu.call(`FIAC_FN_SECTOR_CRC, 8'h00, 8'h00, 8'h03, 1'b0);
        check(cpu.res, crc_zero(1024));
        check(32'({cpu.res_c, 16'(cpu.res_cyc)}), 32'(`FIAC_SECTOR_BYTES) + 32'd3);
        cpu.call(`FIAC_FN_GLOBAL_CRC, 8'h00, 8'h00, 8'h00, 1'b0);
        check(cpu.res, crc_zero(8192));
        fork
            cpu.call(`FIAC_FN_GLOBAL_CRC, 8'h00, 8'h00, 8'h00, 1'b0);
            begin
                repeat (100) @(negedge i_ref_clk);
                i_irq = 1'b1;
            end
        join
        i_irq = 1'b0;
        check(32'({cpu.res_c, cpu.res[7:0]}), 32'h101);
    endtask
    // Watchdog timeout while its reset is disabled, then the shared pin
    task automatic t_wdt_pin();
        i_wdt_timeout = 1'b1;
        @(negedge i_ref_clk);
        i_wdt_timeout = 1'b0;
        check(32'({wdt_irq, wdt_rst}), 32'h2);
        i_power_up = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        check(32'(is_rst), 32'h1);
        i_power_up = 1'b0;
        i_pin_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        check(32'({is_rst, pin_req, pin_in}), 32'h6);
        i_pin_n = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        check(32'({pin_req, pin_in}), 32'h1);
    endtask
    // Programmer stores a new byte; a reset reloads it and every field follows
    task automatic t_cfg_new();
        // Watchdog reset on, pin as input, brownout off, safety on, watchdog oscillator
        dut.u_mem.mem[`FIAC_CODE_BYTES] = 8'h94;
        do_reset(3);
        check(32'({osc, osc_ok, ready}), 32'({`FIAC_OSC_WATCHDOG, 2'b11}));
        check(32'({watchdog_safety_enable, brownout_detect_enable}), 32'h2);
        cpu.call(`FIAC_FN_MISC_READ, 8'h00, 8'h00, `FIAC_SEL_CONFIG, 1'b0);
        check(32'({cpu.res_c, cpu.res[7:0]}), 32'h094);
        // A frozen block must ignore the timeout until enabled again
        ce = 1'b0;
        i_wdt_timeout = 1'b1;
        @(negedge i_ref_clk);
        check(32'({wdt_irq, wdt_rst}), 32'h0);
        ce = 1'b1;
        @(negedge i_ref_clk);
        i_wdt_timeout = 1'b0;
        check(32'({wdt_irq, wdt_rst}), 32'h3);
        i_pin_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        check(32'({is_rst, pin_req, pin_in}), 32'h0);
        i_power_up = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        check(32'({is_rst, pin_req}), 32'h3);
        i_power_up = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        check(32'({is_rst, pin_req}), 32'h0);
        i_pin_n = 1'b1;
        repeat (3) @(negedge i_ref_clk);
    endtask
    initial begin
        do_reset(12);
        t_cfg();
        t_misc();
        t_bad();
        t_erase();
        t_crc();
        t_wdt_pin();
        do_reset(3);
        t_cfg();
        t_cfg_new();
        conclude();
    end
endmodule
